// ===== logic/msar_pkg.sv
`default_nettype none
package msar_pkg;

  // register addresses on the management port
  localparam logic [4:0] MSAR_ADDR_BASIC_STATUS   = 5'h01;
  localparam logic [4:0] MSAR_ADDR_PHY_ID_HIGH    = 5'h02;
  localparam logic [4:0] MSAR_ADDR_PHY_ID_LOW     = 5'h03;
  localparam logic [4:0] MSAR_ADDR_ADVERTISEMENT  = 5'h04;

  // basic status field positions
  localparam int MSAR_BIT_EXT_STATUS      = 8;
  localparam int MSAR_BIT_PREAMBLE_SUPP   = 6;
  localparam int MSAR_BIT_AN_COMPLETE     = 5;
  localparam int MSAR_BIT_REMOTE_FAULT    = 4;
  localparam int MSAR_BIT_AN_CAPABLE      = 3;
  localparam int MSAR_BIT_LINK_STATUS     = 2;
  localparam int MSAR_BIT_EXT_REGS        = 0;
  // advertisement field positions
  localparam int MSAR_BIT_ADV_SPEED_R     = 10;

  // reset values, advertisement write mask and unmapped read value
  localparam logic [15:0] MSAR_RST_PHY_ID         = 16'h0000;
  localparam logic [15:0] MSAR_RST_ADV_NONE       = 16'h0000;
  localparam logic [15:0] MSAR_RST_ADV_SGMII_LOW  = 16'h9001;
  localparam logic [15:0] MSAR_RST_ADV_SGMII_GIG  = 16'h9801;
  localparam logic [15:0] MSAR_RST_ADV_BASEX      = 16'h0020;
  localparam logic [15:0] MSAR_ADV_WRITE_MASK     = 16'hbfff;
  localparam logic [15:0] MSAR_RD_UNMAPPED        = 16'h0000;

  // timing: cycles after reset release before the straps are trusted
  localparam logic [2:0]  MSAR_STRAP_SETTLE       = 3'h4;

  typedef struct packed {
    logic col;
    logic rxDv;
    logic rxd1;
    logic rxd0;
    logic general_output_two_pin;
  } msar_cfg_pins_s;

  typedef struct packed {
    logic       linkUp;
    logic       autonegComplete;
    logic       sgmiiMode;
    logic       cdrLossOfLock;
    logic [1:0] partnerFaultField;
  } msar_pcs_stat_s;

  typedef enum logic [1:0] {
    MSAR_ST_SETTLE = 2'b00,
    MSAR_ST_LOAD   = 2'b01,
    MSAR_ST_RUN    = 2'b10
  } msar_strap_e;

endpackage : msar_pkg
`default_nettype wire

// ===== logic/msar_regs.sv
`timescale 1ns/100ps
`default_nettype none
module msar_regs
  import msar_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  // register access from the station manager frame decoder
  input  wire logic [4:0]     regAddr,
  input  wire logic           regRead,
  input  wire logic           regWrite,
  input  wire logic [15:0]    regWrData,
  output logic      [15:0]    regRdData,
  output logic                regRdValid,
  // configuration pins, asynchronous
  input  wire msar_cfg_pins_s cfgPins,
  input  wire logic           loss_of_signal_input,
  // pcs engine status, same clock
  input  wire msar_pcs_stat_s pcsStat,
  // interrupt status copies and their enables
  input  wire logic           remoteFaultIrqEn,
  input  wire logic           linkStatusIrqEn,
  output logic                remoteFaultCopy,
  output logic                linkStatusCopy,
  output logic                statusIrq,
  // ability word towards the pcs transmitter
  output logic      [15:0]    advertised_ability
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] strapAdvValue(input msar_cfg_pins_s p);
    logic [15:0] v;
    v = MSAR_RST_ADV_NONE;
    if (p.col) begin
      v = p.general_output_two_pin ? MSAR_RST_ADV_BASEX : MSAR_RST_ADV_SGMII_GIG;
    end else if (p.rxDv) begin
      if (!p.rxd1) begin
        v = MSAR_RST_ADV_SGMII_LOW;
        v[MSAR_BIT_ADV_SPEED_R] = p.rxd0;
      end else begin
        v = p.general_output_two_pin ? MSAR_RST_ADV_BASEX : MSAR_RST_ADV_SGMII_GIG;
      end
    end
    return v;
  endfunction : strapAdvValue

  function automatic logic isAddr(input logic [4:0] a, input logic [4:0] ref_a);
    return a == ref_a;
  endfunction : isAddr

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages

  msar_cfg_pins_s cfgS1_q;
  msar_cfg_pins_s cfgS2_q;
  msar_cfg_pins_s cfgS3_q;
  msar_cfg_pins_s cfgStable_q;
  logic [2:0]     losSync_q;
  logic           losStable_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgS1_q <= '0;
      cfgS2_q <= '0;
      cfgS3_q <= '0;
    end else begin
      cfgS1_q <= cfgPins;
      cfgS2_q <= cfgS1_q;
      cfgS3_q <= cfgS2_q;
    end
  end

  // straps count once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgStable_q <= '0;
    end else if (cfgS2_q == cfgS3_q) begin
      cfgStable_q <= cfgS3_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      losSync_q <= 3'h0;
    end else begin
      losSync_q <= {losSync_q[1:0], loss_of_signal_input};
    end
  end

  // accepted level moves only when stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      losStable_q <= 1'b0;
    end else if (losSync_q[1] == losSync_q[2]) begin
      losStable_q <= losSync_q[2];
    end
  end

  logic losAgree;
  logic losRise;
  assign losAgree = losSync_q[1] == losSync_q[2];
  assign losRise  = losAgree && losSync_q[2] && !losStable_q;

  ////////////////////////////////////////////////////////////////////////////
  // address hits: status for the clearing read, advertisement for writes

  logic hitStatus;
  logic hitAdv;
  assign hitStatus = isAddr(regAddr, MSAR_ADDR_BASIC_STATUS);
  assign hitAdv    = isAddr(regAddr, MSAR_ADDR_ADVERTISEMENT);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release

  msar_strap_e strapState_q;
  logic [2:0]  settleCnt_q;
  logic        settleDone;

  assign settleDone = settleCnt_q == MSAR_STRAP_SETTLE - 3'h1;

  // counter stops once the settle state is left
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt_q <= 3'h0;
    end else if (strapState_q == MSAR_ST_SETTLE) begin
      settleCnt_q <= settleCnt_q + 3'h1;
    end
  end

  // pins are only trusted once the synchroniser has filled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapState_q <= MSAR_ST_SETTLE;
    end else begin
      case (strapState_q)
        MSAR_ST_SETTLE: begin
          if (settleDone) begin
            strapState_q <= MSAR_ST_LOAD;
          end
        end
        MSAR_ST_LOAD: begin
          strapState_q <= MSAR_ST_RUN;
        end
        MSAR_ST_RUN: begin
          strapState_q <= MSAR_ST_RUN;
        end
        default: begin
          strapState_q <= MSAR_ST_SETTLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // advertisement register

  logic [15:0] adv_q;
  logic        advWrite;
  logic        strapLoad;
  logic [15:0] advWrMasked;
  assign advWrite    = regWrite && hitAdv;
  assign strapLoad   = strapState_q == MSAR_ST_LOAD;
  assign advWrMasked = regWrData & MSAR_ADV_WRITE_MASK;

  // writes before the strap load are overwritten by it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adv_q <= MSAR_RST_ADV_NONE;
    end else if (strapLoad) begin
      adv_q <= strapAdvValue(cfgStable_q);
    end else if (advWrite) begin
      adv_q <= advWrMasked;
    end
  end

  assign advertised_ability = adv_q;

  ////////////////////////////////////////////////////////////////////////////
  // latched remote fault

  logic statusRead;
  logic faultNow;
  logic faultSet;
  logic remoteFault_q;

  logic faultClear;

  assign statusRead = regRead && hitStatus;

  always_comb begin
    if (pcsStat.sgmiiMode) begin
      // a standing fault blocks the clear
      faultNow = losStable_q || pcsStat.cdrLossOfLock;
    end else begin
      faultNow = pcsStat.partnerFaultField != 2'h0;
    end
  end

  // clear only while no fault stands
  assign faultClear = statusRead && !faultNow;

  always_comb begin
    if (pcsStat.sgmiiMode) begin
      faultSet = losRise || pcsStat.cdrLossOfLock;
    end else begin
      faultSet = pcsStat.partnerFaultField != 2'h0;
    end
  end

  // new fault wins over the clearing read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remoteFault_q <= 1'b0;
    end else if (faultSet) begin
      remoteFault_q <= 1'b1;
    end else if (faultClear) begin
      remoteFault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched link status

  logic linkStatus_q;
  logic linkDrop;
  logic linkSetRead;

  // any cycle with the link down
  assign linkDrop    = !pcsStat.linkUp;
  assign linkSetRead = statusRead && pcsStat.linkUp;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkStatus_q <= 1'b0;
    end else if (linkDrop) begin
      linkStatus_q <= 1'b0;
    end else if (linkSetRead) begin
      linkStatus_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status copies

  assign remoteFaultCopy = remoteFault_q;
  assign linkStatusCopy  = linkStatus_q;
  logic rfIrq;
  logic lkIrq;

  assign rfIrq     = remoteFault_q && remoteFaultIrqEn;
  // a link copy interrupts while it shows a drop
  assign lkIrq     = !linkStatus_q && linkStatusIrqEn;
  assign statusIrq = rfIrq || lkIrq;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [15:0] statusWord;
  logic [15:0] rdMux;

  always_comb begin
    statusWord = 16'h0000;
    statusWord[MSAR_BIT_EXT_STATUS]    = 1'b1;
    statusWord[MSAR_BIT_PREAMBLE_SUPP] = 1'b1;
    statusWord[MSAR_BIT_AN_COMPLETE]   = pcsStat.autonegComplete;
    statusWord[MSAR_BIT_REMOTE_FAULT]  = remoteFault_q;
    statusWord[MSAR_BIT_AN_CAPABLE]    = 1'b1;
    statusWord[MSAR_BIT_LINK_STATUS]   = linkStatus_q;
    statusWord[MSAR_BIT_EXT_REGS]      = 1'b1;
  end

  always_comb begin
    case (regAddr)
      MSAR_ADDR_BASIC_STATUS:  rdMux = statusWord;
      MSAR_ADDR_PHY_ID_HIGH:   rdMux = MSAR_RST_PHY_ID;
      MSAR_ADDR_PHY_ID_LOW:    rdMux = MSAR_RST_PHY_ID;
      MSAR_ADDR_ADVERTISEMENT: rdMux = adv_q;
      default:                 rdMux = MSAR_RD_UNMAPPED;
    endcase
  end

  // read captures the value before the read's own clearing effect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      regRdData <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
    end
  end

endmodule : msar_regs
`default_nettype wire

// ===== tb/msar_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module msar_regs_chk
  import msar_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire logic [4:0]     regAddr,
  input wire logic           regRead,
  input wire logic           regWrite,
  input wire logic [15:0]    regWrData,
  input wire logic [15:0]    regRdData,
  input wire logic           regRdValid,
  input wire msar_pcs_stat_s pcsStat,
  input wire logic           remoteFaultIrqEn,
  input wire logic           linkStatusIrqEn,
  input wire logic           remoteFaultCopy,
  input wire logic           linkStatusCopy,
  input wire logic           statusIrq,
  input wire logic [15:0]    advertised_ability
);
  // early writes are lost to the strap load, so skip them
  logic [2:0] upCnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h7)
      upCnt_q <= upCnt_q + 3'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  stat_const_a: assert property (regRead && regAddr == 5'h01 |=>
    regRdValid && (regRdData & 16'hffcb) == 16'h0149) else $error("status word");
  id_zero_a: assert property (regRead && regAddr inside {5'h02, 5'h03} |=>
    regRdValid && regRdData == 16'h0000) else $error("id not zero");
  link_drop_a: assert property (!pcsStat.linkUp |-> ##[1:2] !linkStatusCopy)
    else $error("link not low");
  link_set_a: assert property (regRead && regAddr == 5'h01 && pcsStat.linkUp ##1 pcsStat.linkUp
    |-> ##[0:1] linkStatusCopy) else $error("link not set");
  rf_set_a: assert property ((pcsStat.sgmiiMode ? pcsStat.cdrLossOfLock :
    pcsStat.partnerFaultField != 2'b00) |-> ##[1:2] remoteFaultCopy) else $error("fault missed");
  rf_hold_a: assert property (remoteFaultCopy && !regRead && !$past(regRead) |=> remoteFaultCopy)
    else $error("fault lost");
  irq_mix_a: assert property (statusIrq == (remoteFaultIrqEn && remoteFaultCopy ||
    linkStatusIrqEn && !linkStatusCopy)) else $error("irq wrong");
  adv_wr_a: assert property (upCnt_q == 3'h7 && regWrite && regAddr == 5'h04 |=>
    advertised_ability == ($past(regWrData) & 16'hbfff)) else $error("adv write");
endmodule : msar_regs_chk
bind msar_regs msar_regs_chk u_chk (.*);
`default_nettype wire

// ===== tb/msar_mgr.sv
`timescale 1ns/100ps
`default_nettype none
module msar_mgr (
  input  wire logic        clk,
  input  wire logic        regRdValid,
  input  wire logic [15:0] regRdData,
  output var logic  [4:0]  regAddr,
  output var logic         regRead,
  output var logic         regWrite,
  output var logic  [15:0] regWrData
);
  initial begin
    regAddr = 5'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWrData = 16'h0000;
  end
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
    end
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    // stale data never looks valid
    regWrData <= ~d;
  endtask : wr
endmodule : msar_mgr
`default_nettype wire

// ===== tb/mii_status_id_advert_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mii_status_id_advert_regs_tb_top;
  import msar_pkg::*;
  logic           clk;
  logic           reset_n;
  logic [4:0]     regAddr;
  logic           regRead;
  logic           regWrite;
  logic [15:0]    regWrData;
  logic [15:0]    regRdData;
  logic           regRdValid;
  msar_cfg_pins_s cfgPins;
  logic           los;
  msar_pcs_stat_s pcs;
  logic           rfEn;
  logic           lkEn;
  logic           rfCopy;
  logic           lkCopy;
  logic           irq;
  logic [15:0]    adv;
  int             bad_count;
  int             checks;
  int             cyc;
  // strap sets: col rxDv rxd1 rxd0 general_output_two_pin
  logic [4:0]     cf [7] = '{5'h00, 5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h10, 5'h11};
  logic [15:0]    ex [7] = '{16'h0000, 16'h9001, 16'h9401, 16'h9801, 16'h0020, 16'h9801, 16'h0020};
  localparam logic [4:0] ST = MSAR_ADDR_BASIC_STATUS;
  msar_regs dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .cfgPins(cfgPins),
    .loss_of_signal_input(los), .pcsStat(pcs), .remoteFaultIrqEn(rfEn), .linkStatusIrqEn(lkEn),
    .remoteFaultCopy(rfCopy), .linkStatusCopy(lkCopy), .statusIrq(irq), .advertised_ability(adv));
  msar_mgr mgr (.clk(clk), .regRdValid(regRdValid), .regRdData(regRdData), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    mgr.rd(a, v);
    chk($sformatf("reg %0h", a), v, exp);
  endtask : rc
  task automatic do_reset(input logic [4:0] c);
    @(posedge clk);
    reset_n <= 1'b0;
    cfgPins <= c;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset
  initial begin
    reset_n = 1'b0;
    cfgPins = '0;
    los = 1'b0;
    pcs = '0;
    rfEn = 1'b1;
    lkEn = 1'b1;
    bad_count = 0;
    checks = 0;
    for (int i = 0; i < 7; i++) begin
      do_reset(cf[i]);
      rc(MSAR_ADDR_ADVERTISEMENT, ex[i]);
      chk("adv", adv, ex[i]);
    end
    $display("straps done");
    rc(5'h02, 16'h0000);
    mgr.wr(5'h03, 16'hffff);
    rc(5'h03, 16'h0000);
    rc(5'h1f, 16'h0000);
    mgr.wr(5'h04, 16'hffff);
    rc(5'h04, 16'hbfff);
    chk("adv", adv, 16'hbfff);
    $display("regs done");
    rc(ST, 16'h0149);
    chk("irq", 16'(irq), 16'h0001);
    pcs.linkUp <= 1'b1;
    pcs.autonegComplete <= 1'b1;
    rc(ST, 16'h0169);
    rc(ST, 16'h016d);
    chk("irq", 16'(irq), 16'h0000);
    chk("lkcopy", 16'(lkCopy), 16'h0001);
    pcs.linkUp <= 1'b0;
    @(posedge clk);
    pcs.linkUp <= 1'b1;
    rc(ST, 16'h0169);
    rc(ST, 16'h016d);
    $display("link done");
    pcs.partnerFaultField <= 2'b10;
    @(posedge clk);
    pcs.partnerFaultField <= 2'b00;
    repeat (2) @(posedge clk);
    chk("irq", 16'(irq), 16'h0001);
    chk("rfcopy", 16'(rfCopy), 16'h0001);
    rfEn <= 1'b0;
    @(posedge clk);
    chk("irq", 16'(irq), 16'h0000);
    rfEn <= 1'b1;
    rc(ST, 16'h017d);
    rc(ST, 16'h016d);
    pcs.partnerFaultField <= 2'b01;
    rc(ST, 16'h017d);
    rc(ST, 16'h017d);
    pcs.partnerFaultField <= 2'b00;
    pcs.sgmiiMode <= 1'b1;
    rc(ST, 16'h017d);
    los <= 1'b1;
    repeat (6) @(posedge clk);
    los <= 1'b0;
    repeat (6) @(posedge clk);
    rc(ST, 16'h017d);
    rc(ST, 16'h016d);
    pcs.cdrLossOfLock <= 1'b1;
    @(posedge clk);
    pcs.cdrLossOfLock <= 1'b0;
    rc(ST, 16'h017d);
    $display("fault done");
    close_out();
  end
endmodule : mii_status_id_advert_regs_tb_top
`default_nettype wire
